// ### logic/ahp_host_port.sv
// Host port with second control register, offset calibration and result path
// Overview of operation
// RULE1: Reset bit holds device reset until cleared
// RULE2: Sync clear bit resets sync generator
// RULE3: Host sets sync clear for multichannel
// RULE4: Direction mode: write pin gives direction
// RULE5: Separate mode: distinct read and write strobes
// RULE6: Format bit picks twos-complement or binary
// RULE7: Calibration bit forces zero input conversion
// RULE8: Stored offset subtracted from later results
// RULE9: Read strobe active when all valid
// RULE10: Read strobe ends on first inactive
// RULE11: Read strobe drives data and enables
// RULE12: Write strobe active when all valid
// RULE13: Write strobe ends on first inactive
// RULE14: Write strobe loads addressed control register
// RULE15: Host ties read pin high in direction mode
// RULE16: Top bits 01 select second register
`default_nettype none
module ahp_host_port
(
    // Clock and reset
    input  wire logic                       CLK_I,
    input  wire logic                       RST_N_I,
    // Host pins
    input  wire logic                       CHIP_SELECT_LOW_ACTIVE_N_I,
    input  wire logic                       CHIP_SELECT_HIGH_ACTIVE_I,
    input  wire logic                       RD_N_I,
    input  wire logic                       WR_N_I,
    input  wire logic [ahp_pkg::DATA_W-1:0] DATA_I,
    output logic      [ahp_pkg::DATA_W-1:0] DATA_O,
    output logic                            DATA_OE_O,
    // Converter core
    input  wire logic [ahp_pkg::RES_W-1:0]  CONV_RESULT_I,
    input  wire logic                       CONV_VALID_I,
    output logic                            CONV_ZERO_INPUT_O,
    output logic                            SYNC_GEN_CLEAR_O,
    output logic                            DEVICE_RESET_O,
    output logic      [9:0]                 CTRL0_O,
    output logic      [9:0]                 CTRL1_O
);
    import ahp_pkg::*;

    ahp_pins_s pins;
    logic      rd_int;
    logic      wr_int;
    logic      wr_int_d;
    logic [9:0] ctrl0;
    logic [9:0] ctrl1;
    logic [RES_W-1:0] offset;
    logic [RES_W-1:0] result;
    logic      sync_clr;
    ahp_cal_e  cal_state;
    ahp_cal_e  next_cal_state;

    assign pins = '{cs_n: CHIP_SELECT_LOW_ACTIVE_N_I, cs: CHIP_SELECT_HIGH_ACTIVE_I,
                    rd_n: RD_N_I, wr_n: WR_N_I};

    ahp_strobe u_strobe
    (
        .pins_i    (pins),
        .dir_sel_i (ctrl1[BIT_DIR_SEL]),
        .rd_int_o  (rd_int),
        .wr_int_o  (wr_int)
    );

    // Load on the closing edge of the write strobe, when data is settled
    wire        wr_done  = wr_int_d & ~wr_int;
    logic [DATA_W-1:0] wr_word;
    wire [1:0]  wr_addr  = wr_word[ADDR_HI:ADDR_LO];
    wire        hit_cr1  = wr_done & (wr_addr == ADDR_CR1);               // [RULE16]
    wire        hit_cr0  = wr_done & (wr_addr == ADDR_CR0);               // [RULE14]
    wire        in_reset = ctrl1[BIT_RESET];

    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            wr_int_d <= 1'b0;
            wr_word  <= '0;
        end
        else
        begin
            wr_int_d <= wr_int;
            if (wr_int)
                wr_word <= DATA_I;
        end
    end

    // Reset bit keeps both registers at defaults, except it remains writable
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            ctrl0 <= CR0_RESET;
            ctrl1 <= CR1_RESET;
        end
        else if (hit_cr1)
        begin
            if (wr_word[BIT_RESET])
                ctrl1 <= CR1_RESET | 10'h001;                            // [RULE1]
            else
                ctrl1 <= (wr_word[9:0] & ~RSVD_MASK & ~10'h200)
                         | CR1_RESET & RSVD_MASK;                        // [RULE14]
            if (wr_word[BIT_RESET])
                ctrl0 <= CR0_RESET;                                      // [RULE1]
        end
        else if (hit_cr0 && !in_reset)
            ctrl0 <= wr_word[9:0];                                       // [RULE14]
        else if (in_reset)
            ctrl0 <= CR0_RESET;                                          // [RULE1]
    end

    // One-cycle sync clear pulse per write carrying the bit
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            sync_clr <= 1'b0;
        else
            sync_clr <= hit_cr1 & wr_word[BIT_SYNC_CLR];                 // [RULE2]
    end

    // Calibration: zero input, wait one conversion, store it
    always_comb
    begin
        next_cal_state = cal_state;
        case (cal_state)
            ST_IDLE:
                if (hit_cr1 && wr_word[BIT_OFFSET] && !wr_word[BIT_RESET])
                    next_cal_state = ST_CAL_WAIT;                        // [RULE7]
            ST_CAL_WAIT:
                if (in_reset)
                    next_cal_state = ST_IDLE;
                else if (CONV_VALID_I)
                    next_cal_state = ST_CAL_DONE;
            ST_CAL_DONE:
                next_cal_state = ST_IDLE;
            default:
                next_cal_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            cal_state <= ST_IDLE;
            offset    <= '0;
        end
        else
        begin
            cal_state <= next_cal_state;
            if (cal_state == ST_CAL_WAIT && CONV_VALID_I && !in_reset)
                offset <= CONV_RESULT_I;                                 // [RULE8]
        end
    end

    // Offset removal then format: MSB flip turns offset binary into twos complement
    wire [RES_W-1:0] corrected = CONV_RESULT_I - offset;                 // [RULE8]
    wire [RES_W-1:0] formatted = ctrl1[BIT_FORMAT] ? corrected
                                 : {~corrected[RES_W-1], corrected[RES_W-2:0]}; // [RULE6]

    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            result <= '0;
        else if (in_reset)
            result <= '0;
        else if (CONV_VALID_I && cal_state != ST_CAL_WAIT)
            result <= formatted;
    end

    // Buffers enabled only while the read strobe is live
    assign DATA_OE_O = rd_int;                                           // [RULE11]
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            DATA_O <= '0;
        else
            DATA_O <= {{(DATA_W-RES_W){1'b0}}, result};                  // [RULE11]
    end

    assign CONV_ZERO_INPUT_O = (cal_state == ST_CAL_WAIT);               // [RULE7]
    assign SYNC_GEN_CLEAR_O  = sync_clr;
    assign DEVICE_RESET_O    = in_reset;
    assign CTRL0_O           = ctrl0;
    assign CTRL1_O           = ctrl1;

    // Pin-level view of the read strobe, derived apart from the strobe former
    wire pins_selected = !CHIP_SELECT_LOW_ACTIVE_N_I && CHIP_SELECT_HIGH_ACTIVE_I;
    wire pins_reading  = pins_selected && WR_N_I && (ctrl1[BIT_DIR_SEL] || !RD_N_I);

    sequence sync_pulse_seq;
        SYNC_GEN_CLEAR_O ##1 !SYNC_GEN_CLEAR_O;
    endsequence

    AST_OE_FOLLOWS_STROBE: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [RULE11]
        DATA_OE_O == pins_reading)
        else $error("output enable does not follow the read pins");
    AST_NO_DUAL_STROBE: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [RULE9]
        !(rd_int && wr_int))
        else $error("read and write strobes both active");
    AST_SYNC_PULSE: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [RULE2]
        hit_cr1 && wr_word[BIT_SYNC_CLR] |=> sync_pulse_seq)
        else $error("sync clear pulse wrong");
    AST_RESET_HOLDS: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [RULE1]
        in_reset && !hit_cr1 |=> in_reset && ctrl0 == CR0_RESET)
        else $error("reset not held");
    AST_CR1_LOAD: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [RULE14]
        hit_cr1 && !wr_word[BIT_RESET] |=> ctrl1[BIT_DIR_SEL] == $past(wr_word[BIT_DIR_SEL]))
        else $error("second register not loaded");
    AST_RSVD_KEPT: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [RULE16]
        (ctrl1 & RSVD_MASK) == (CR1_RESET & RSVD_MASK) && !ctrl1[BIT_RSVD9])
        else $error("reserved control bits left their fixed values");
    AST_CAL_START: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [RULE7]
        cal_state == ST_IDLE && hit_cr1 && wr_word[BIT_OFFSET] && !wr_word[BIT_RESET]
        |=> CONV_ZERO_INPUT_O) else $error("calibration did not start");
    AST_OFFSET_STORE: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [RULE8]
        cal_state == ST_CAL_WAIT && CONV_VALID_I && !in_reset
        |=> offset == $past(CONV_RESULT_I)) else $error("offset not stored");
    AST_DIR_MODE_READ: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [RULE4]
        ctrl1[BIT_DIR_SEL] && !CHIP_SELECT_LOW_ACTIVE_N_I && CHIP_SELECT_HIGH_ACTIVE_I
        && WR_N_I |-> rd_int) else $error("direction mode read missing");
    AST_SEP_WRITE: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [RULE12]
        !ctrl1[BIT_DIR_SEL] && !CHIP_SELECT_LOW_ACTIVE_N_I && CHIP_SELECT_HIGH_ACTIVE_I
        && !WR_N_I && RD_N_I |-> wr_int) else $error("separate write strobe missing");
endmodule : ahp_host_port
`default_nettype wire

// ### logic/ahp_pkg.sv
// Package for the converter host port control logic
`default_nettype none
package ahp_pkg;
    localparam int DATA_W        = 12;
    localparam int RES_W         = 10;
    // Address field in the top two bits
    localparam int ADDR_HI       = 11;
    localparam int ADDR_LO       = 10;
    localparam logic [1:0] ADDR_CR0 = 2'h0;
    localparam logic [1:0] ADDR_CR1 = 2'h1;
    // Second control register fields
    localparam int BIT_RESET     = 0;
    localparam int BIT_SYNC_CLR  = 1;
    localparam int BIT_DIR_SEL   = 6;
    localparam int BIT_FORMAT    = 7;
    localparam int BIT_OFFSET    = 8;
    localparam int BIT_RSVD9     = 9;
    localparam logic [9:0] CR1_RESET = 10'h030;
    localparam logic [9:0] CR0_RESET = 10'h020;
    localparam logic [9:0] RSVD_MASK = 10'h03C;

    // Pin bundle from the host
    typedef struct packed {
        logic cs_n;
        logic cs;
        logic rd_n;
        logic wr_n;
    } ahp_pins_s;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CAL_WAIT,
        ST_CAL_DONE
    } ahp_cal_e;
endpackage : ahp_pkg
`default_nettype wire

// ### logic/ahp_strobe.sv
// Internal read and write strobe former
`default_nettype none
module ahp_strobe
(
    // Host pins
    input  wire ahp_pkg::ahp_pins_s pins_i,
    // Mode
    input  wire logic               dir_sel_i,
    // Strobes, active high internally
    output logic                    rd_int_o,
    output logic                    wr_int_o
);
    import ahp_pkg::*;
    wire cs_ok    = ~pins_i.cs_n & pins_i.cs;
    // Combined mode: wr_n pin carries direction, read strobe pin ignored
    wire rd_sep   = ~pins_i.rd_n & pins_i.wr_n;
    wire wr_sep   = ~pins_i.wr_n & pins_i.rd_n;
    assign rd_int_o = cs_ok & (dir_sel_i ? pins_i.wr_n : rd_sep);   // [RULE4] [RULE5] [RULE9] [RULE10]
    assign wr_int_o = cs_ok & (dir_sel_i ? ~pins_i.wr_n : wr_sep);  // [RULE4] [RULE5] [RULE12] [RULE13]
endmodule : ahp_strobe
`default_nettype wire

// ### verif/ahp_host_model.sv
// Host bus master model driving the converter port pins
`default_nettype none
module ahp_host_model
(
    // Clock, mode and port answer
    input  wire logic        clk_i,
    input  wire logic        dir_mode_i,
    input  wire logic [11:0] data_i,
    input  wire logic        oe_i,
    // Port pins
    output logic             cs_n_o,
    output logic             cs_o,
    output logic             rd_n_o,
    output logic             wr_n_o,
    output logic [11:0]      data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        {cs_n_o, cs_o, rd_n_o, wr_n_o} = 4'hA;
        data_o = 12'hFFF;
    end
    // Strobe held 3 cycles, then the answer settles for 5
    task automatic write(input logic [11:0] w);
        @(posedge clk_i);
        data_o <= w;
        {cs_n_o, cs_o, wr_n_o} <= 3'h2;
        repeat (3) @(posedge clk_i);
        {cs_n_o, cs_o} <= 2'h2;
        data_o <= ~w;
        @(posedge clk_i);
        wr_n_o <= 1'b1;
        repeat (5) @(posedge clk_i);
    endtask : write
    task automatic read(output logic [11:0] d, output logic oe);
        @(posedge clk_i);
        {cs_n_o, cs_o} <= 2'h1;
        if (!dir_mode_i) rd_n_o <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1 d = data_i;
        oe = oe_i;
        @(posedge clk_i);
        {cs_n_o, cs_o, rd_n_o} <= 3'h5;
    endtask : read
    // Raw pin pattern; the bus word addresses nothing
    task automatic set_pins(input logic [3:0] p);
        @(posedge clk_i);
        data_o <= 12'hC00;
        {cs_n_o, cs_o, wr_n_o} <= {p[3:2], p[0]};
        rd_n_o <= p[1] | dir_mode_i;
        @(negedge clk_i);
    endtask : set_pins
endmodule : ahp_host_model
`default_nettype wire

// ### verif/tb_top.sv
// Self-checking bench for the converter host port
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import ahp_pkg::*;
    logic        clk = 1'b0, rst_n = 1'b0, dir = 1'b0, conv_val = 1'b0;
    logic        cs_n, cs, rd_n, wr_n, oe, zero, sclr, dres, roe, fmt;
    logic [11:0] din, dout, rd, w;
    logic [9:0]  conv_res = 10'h000, c0, c1, off, raw;
    logic [31:0] seed = 32'd32855;
    int          bad_count = 0, tests_run = 0, cyc = 0, sync_cnt = 0, i, s;
    ahp_host_port u_dut (.CLK_I(clk), .RST_N_I(rst_n), .CHIP_SELECT_LOW_ACTIVE_N_I(cs_n),
        .CHIP_SELECT_HIGH_ACTIVE_I(cs), .RD_N_I(rd_n), .WR_N_I(wr_n), .DATA_I(din),
        .DATA_O(dout), .DATA_OE_O(oe), .CONV_RESULT_I(conv_res), .CONV_VALID_I(conv_val),
        .CONV_ZERO_INPUT_O(zero), .SYNC_GEN_CLEAR_O(sclr), .DEVICE_RESET_O(dres),
        .CTRL0_O(c0), .CTRL1_O(c1));
    ahp_host_model u_host (.clk_i(clk), .dir_mode_i(dir), .data_i(dout), .oe_i(oe),
        .cs_n_o(cs_n), .cs_o(cs), .rd_n_o(rd_n), .wr_n_o(wr_n), .data_o(din));
    initial forever #12.5 clk = ~clk;
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (sclr === 1'b1) sync_cnt <= sync_cnt + 1;
        if (cyc == 10000)
        begin
            bad_count++;
            conclude();
        end
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    // Expected result after offset removal and format choice
    function automatic logic [11:0] exp_res(input logic [9:0] r, o, input logic f);
        return {2'h0, (r - o) ^ (f ? 10'h000 : 10'h200)};
    endfunction : exp_res
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic conv(input logic [9:0] r);
        @(posedge clk);
        conv_res <= r;
        conv_val <= 1'b1;
        @(posedge clk);
        conv_val <= 1'b0;
        conv_res <= ~r;
        repeat (3) @(posedge clk);
    endtask : conv
    task automatic sweep();
        for (i = 0; i < 16; i++)
        begin
            if (dir && !i[1]) continue;
            u_host.set_pins(i[3:0]);
            check(oe, !i[3] & i[2] & i[0] & (dir | !i[1]));
        end
        u_host.set_pins(4'hA);
        check(c0, CR0_RESET);
    endtask : sweep
    task automatic conclude();
        if (bad_count == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : conclude
    initial
    begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        check(c1, CR1_RESET);
        sweep();
        u_host.write(12'h440);
        dir <= 1'b1;
        sweep();
        for (s = 0; s < 10; s++)
        begin
            w = 12'h400 | 12'(rnd() & 32'h0FE);
            if (s == 0) w = 12'h4FE;
            i = sync_cnt;
            u_host.write(w);
            check(c1 & 10'h3FD, (w[9:0] & 10'h1C1) | 10'h030);
            check(sync_cnt - i, w[1]);
            dir <= w[6];
            raw = 10'(rnd());
            conv(raw);
            u_host.read(rd, roe);
            check(rd, exp_res(raw, 10'h000, w[7]));
            check(roe, 1'b1);
            w = 12'(rnd() & 32'h3FF);
            u_host.write(w);
            check(c0, w[9:0]);
            u_host.write(12'h800 | 12'(rnd() & 32'h7FF));
            check(c0, w[9:0]);
        end
        dir <= 1'b0;
        fmt = 1'(rnd());
        off = 10'(rnd() & 32'h03F);
        u_host.write({2'h1, 10'h100 | {2'h0, fmt, 7'h00}});
        check(zero, 1'b1);
        conv(off);
        check(zero, 1'b0);
        for (s = 0; s < 6; s++)
        begin
            raw = 10'h200 | 10'(rnd() & 32'h1FF);
            if (s == 0) raw = 10'h3FF;
            conv(raw);
            u_host.read(rd, roe);
            check(rd, exp_res(raw, off, fmt));
        end
        u_host.write(12'h401);
        check(dres, 1'b1);
        check(c1 & 10'h3FD, 10'h031);
        check(c0, CR0_RESET);
        u_host.write(12'h0FF);
        check(c0, CR0_RESET);
        u_host.write(12'h400);
        check(dres, 1'b0);
        check(c1, CR1_RESET);
        conclude();
    end
endmodule : tb_top
`default_nettype wire
